// *** dv/logic_output_conditioner_bench.sv ***
// Self-checking bench of the logic output conditioner.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module logic_output_conditioner_bench;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [27:0] cond_in = 28'h0000000;
	logic [3:0] app_cond_in = 4'h0;
	logic [2:0] app_valid_in = 3'h0;
	logic [5:0] app_code_in = 6'h00;
	wire logic [15:0] rdata_out;
	wire logic [2:0] pins;
	wire logic [11:0] ana;
	wire logic contact;
	int num_errors = 0;
	int compares = 0;
	initial forever #25 clk_sys_in = ~clk_sys_in;
	logic_output_conditioner #(.TICK_CYCLES(4)) dut (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .cond_in(cond_in),
		.app_cond_in(app_cond_in), .app_valid_in(app_valid_in),
		.app_code_in(app_code_in), .ext_logic_out_a_out(pins[0]),
		.ext_logic_out_b_out(pins[1]),
		.analog_reuse_logic_out_out(pins[2]),
		.first_analog_out_out(ana)
	);
	relay_model load (.clk_sys_in(clk_sys_in), .coil_in(pins[0]),
		.contact_out(contact));
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1;
		`CHK($sformatf("reg %h", a), e, rdata_out)
	endtask : rdchk
	task automatic setc(input int i, input logic v);
		@(posedge clk_sys_in);
		cond_in[i] <= v;
	endtask : setc
	task automatic stay(input int i, input logic v, input int n);
		logic ok;
		ok = 1'b1;
		repeat (n) begin
			@(posedge clk_sys_in);
			#1;
			ok &= (pins[i] === v);
		end
		`CHK("pin steady", 1'b1, ok)
	endtask : stay
	task automatic reach(input int i, input logic v, input int n);
		#1;
		for (int k = 0; k < n && pins[i] !== v; k++) begin
			@(posedge clk_sys_in);
			#1;
		end
		`CHK("pin level", v, pins[i])
	endtask : reach
	task automatic summarize();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (2000) @(posedge clk_sys_in);
		num_errors++;
		summarize();
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1;
		`CHK("analog", 12'h000, ana)
		for (int a = 0; a < 14; a++) rdchk(a[3:0], 16'h0000);
		$display("test reset done");
		wr(4'h1, 16'hFFFF);
		rdchk(4'h1, 16'hEA60);
		wr(4'h2, 16'hFFFF);
		rdchk(4'h2, 16'h270F);
		wr(4'h1, 16'h0003);
		wr(4'h2, 16'h0002);
		wr(4'h0, 16'h0002);
		wr(4'h0, 16'h001E);
		rdchk(4'h0, 16'h0002);
		$display("test settings done");
		setc(2, 1'b1);
		stay(0, 1'b0, 12);
		reach(0, 1'b1, 5);
		@(posedge clk_sys_in);
		#1;
		`CHK("contact", 1'b1, contact)
		setc(2, 1'b0);
		stay(0, 1'b1, 8);
		reach(0, 1'b0, 5);
		setc(2, 1'b1);
		stay(0, 1'b0, 3);
		setc(2, 1'b0);
		stay(0, 1'b0, 4);
		setc(2, 1'b1);
		stay(0, 1'b0, 12);
		reach(0, 1'b1, 5);
		$display("test timers done");
		wr(4'h7, 16'h0001);
		wr(4'h4, 16'h0003);
		reach(1, 1'b1, 2);
		setc(3, 1'b1);
		reach(1, 1'b0, 1);
		wr(4'h7, 16'h0000);
		reach(1, 1'b1, 2);
		wr(4'h5, 16'h0005);
		wr(4'h6, 16'h0005);
		wr(4'h7, 16'h0001);
		wr(4'h4, 16'h0001);
		stay(1, 1'b0, 3);
		setc(1, 1'b1);
		reach(1, 1'b1, 1);
		setc(1, 1'b0);
		reach(1, 1'b0, 1);
		$display("test polarity done");
		wr(4'h9, 16'h0003);
		@(posedge clk_sys_in);
		app_code_in <= 6'h10;
		app_valid_in <= 3'h4;
		rdchk(4'h8, 16'h001D);
		@(posedge clk_sys_in);
		app_cond_in <= 4'h2;
		reach(2, 1'b1, 1);
		@(posedge clk_sys_in);
		#1;
		`CHK("analog", 12'hFFF, ana)
		rdchk(4'hC, 16'h0055);
		$display("test application done");
		summarize();
	end
endmodule : logic_output_conditioner_bench
`default_nettype wire

// *** dv/relay_model.sv ***
// Relay model that stands on an extension logic output.
`timescale 1ns/10ps
`default_nettype none
module relay_model (
	// Clock
	input wire logic clk_sys_in,
	// Coil and contact
	input wire logic coil_in,
	output var logic contact_out
);
	// The contact closes a cycle after the coil, so a glitch-free pin
	// is seen the same way by the load as at the port.
	always_ff @(posedge clk_sys_in) begin
		contact_out <= coil_in;
	end
endmodule : relay_model
`default_nettype wire

// *** hdl/chan_if.sv ***
// Signals between the conditioner core and one output channel.
`timescale 1ns/10ps
`default_nettype none
interface chan_if;
	logic tick;
	logic cond;
	logic zero_on;
	logic zero_hold;
	logic force_pos;
	logic active_low;
	logic [15:0] on_delay;
	logic [15:0] hold_time;
	logic state;
	logic pin;
	modport ctrl (output tick, cond, zero_on, zero_hold, force_pos,
		active_low, on_delay, hold_time, input state, pin);
	modport chan (input tick, cond, zero_on, zero_hold, force_pos,
		active_low, on_delay, hold_time, output state, pin);
endinterface : chan_if
`default_nettype wire

// *** hdl/chan_timer.sv ***
// One output channel: on-delay, hold time and polarity.
`timescale 1ns/10ps
`default_nettype none
module chan_timer (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Channel
	chan_if.chan c
);
	// ****************************************************************
	// Timer
	// ****************************************************************
	logic [15:0] cnt;
	wire differ = c.cond != c.state;
	wire [15:0] limit_on = c.zero_on ? 16'h0000 : c.on_delay; // RULE6
	wire [15:0] limit_hold = c.zero_hold ? 16'h0000 : c.hold_time; // RULE7
	wire [15:0] limit = c.cond ? limit_on : limit_hold; // RULE1 RULE2
	wire [15:0] cnt_inc = cnt + 16'h0001;
	// The tick runs free, so the first tick after a change may come at
	// once; expiring on the tick after the count has reached the limit
	// keeps the delay from ever being shorter than the setting.
	wire expire = (limit == 16'h0000) ||
		(c.tick && cnt >= limit); // RULE1 RULE2
	wire next_state = (differ && expire) ? c.cond : c.state;
	// A condition that reverts drops the partial count. RULE10
	wire [15:0] next_cnt = (!differ || expire) ? 16'h0000 :
		(c.tick ? cnt_inc : cnt);
	wire eff_neg = c.active_low && !c.force_pos; // RULE5
	wire next_pin = next_state ^ eff_neg; // RULE3 RULE4

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt <= 16'h0000; // RULE11
			c.state <= 1'b0;
			c.pin <= 1'b0;
		end else begin
			cnt <= next_cnt;
			c.state <= next_state;
			c.pin <= next_pin;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_rise_zero;
		c.cond && !c.state && c.zero_on;
	endsequence
	sequence s_fall_zero;
		!c.cond && c.state && c.zero_hold;
	endsequence

	a_forced_rise: assert property ( // RULE6
		@(posedge clk_sys_in) disable iff (rst_in)
		s_rise_zero |=> c.state)
		else $error("forced zero on-delay did not act at once");
	a_forced_fall: assert property ( // RULE7
		@(posedge clk_sys_in) disable iff (rst_in)
		s_fall_zero |=> !c.state)
		else $error("forced zero hold time did not act at once");
	a_no_early_rise: assert property ( // RULE1
		@(posedge clk_sys_in) disable iff (rst_in)
		$rose(c.state) && !$past(c.zero_on) |->
		$past(c.on_delay) == 16'h0000 ||
		($past(c.tick) && $past(cnt) >= $past(c.on_delay)))
		else $error("output rose before on-delay elapsed");
	a_no_early_fall: assert property ( // RULE2
		@(posedge clk_sys_in) disable iff (rst_in)
		$fell(c.state) && !$past(c.zero_hold) |->
		$past(c.hold_time) == 16'h0000 ||
		($past(c.tick) && $past(cnt) >= $past(c.hold_time)))
		else $error("output fell before hold time elapsed");
	a_revert_clear: assert property ( // RULE10
		@(posedge clk_sys_in) disable iff (rst_in)
		c.cond == c.state |=> cnt == 16'h0000 && c.state == $past(c.state))
		else $error("timer not abandoned on revert");
	a_polarity_map: assert property ( // RULE4
		@(posedge clk_sys_in) disable iff (rst_in)
		##1 c.pin == (c.state ^ $past(c.active_low && !c.force_pos)))
		else $error("pin does not follow state and polarity");
	a_force_high: assert property ( // RULE5
		@(posedge clk_sys_in) disable iff (rst_in)
		c.force_pos |=> c.pin == c.state)
		else $error("forced active-high not applied");
endmodule : chan_timer
`default_nettype wire

// *** hdl/loc_pkg.sv ***
// Constants, types and register map of the logic output conditioner.
package loc_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] ON_DELAY_MAX_MS = 16'hEA60;
	localparam logic [15:0] HOLD_MAX_MS = 16'h270F;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] ON_DELAY_RESET = 16'h0000;
	localparam logic [15:0] HOLD_RESET = 16'h0000;
	localparam logic POLARITY_RESET = 1'h0;
	// ****************************************************************
	// Assignment codes
	// ****************************************************************
	typedef logic [4:0] sel_t;
	localparam sel_t SEL_NONE = 5'h00;
	localparam sel_t SEL_NO_FAULT = 5'h01;
	localparam sel_t SEL_APP_FIRST = 5'h1C;
	localparam sel_t SEL_LINE_CTR = 5'h1C;
	localparam sel_t SEL_OUT_CTR = 5'h1D;
	localparam sel_t SEL_DC_PRE = 5'h1E;
	localparam sel_t SEL_DAMPER = 5'h1F;
	localparam int NCOND = 28;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int NCHAN = 3;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [1:0] FLD_ASSIGN = 2'h0;
	localparam logic [1:0] FLD_ON_DELAY = 2'h1;
	localparam logic [1:0] FLD_HOLD = 2'h2;
	localparam logic [1:0] FLD_POLARITY = 2'h3;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int STATUS_PIN_POS = 4;
endpackage : loc_pkg

// *** hdl/logic_output_conditioner.sv ***
// Logic output conditioner: two extension outputs and a reused analog output.
// Functional notes
// RULE1: Output follows a rising condition after the on-delay, 0..60000 ms.
// RULE2: Output follows a falling condition after the hold time, 0..9999 ms.
// RULE3: Active-high polarity drives 1 while the condition is true.
// RULE4: Active-low polarity drives 0 while true and 1 otherwise.
// RULE5: No-fault, precharge and line contactor assignments force active-high.
// RULE6: Zero on-delay for no-fault, output, precharge, line contactor codes.
// RULE7: No-fault, precharge and line contactor assignments zero hold time.
// RULE8: Contactor, precharge, damper codes set only by application logic.
// RULE9: Reused analog output gives minimum level for 0, maximum for 1.
// RULE10: A condition reverting mid-timer abandons the timer, output unchanged.
// RULE11: Timers count a one-millisecond tick; counters clear on reset.
`timescale 1ns/10ps
`default_nettype none
module logic_output_conditioner #(
	parameter int TICK_CYCLES = loc_pkg::TICK_CYCLES,
	parameter int ANA_W = 12,
	parameter logic [ANA_W-1:0] ANA_MIN = 12'h000,
	parameter logic [ANA_W-1:0] ANA_MAX = 12'hFFF
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port
	input wire logic [loc_pkg::ADDR_W-1:0] addr_in,
	input wire logic [loc_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [loc_pkg::DATA_W-1:0] rdata_out,
	// Internal conditions
	input wire logic [loc_pkg::NCOND-1:0] cond_in,
	input wire logic [3:0] app_cond_in,
	// Application assignments, one per channel
	input wire logic [loc_pkg::NCHAN-1:0] app_valid_in,
	input wire logic [2*loc_pkg::NCHAN-1:0] app_code_in,
	// Outputs
	output logic ext_logic_out_a_out,
	output logic ext_logic_out_b_out,
	output logic analog_reuse_logic_out_out,
	output logic [ANA_W-1:0] first_analog_out_out
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	logic [TW-1:0] tick_cnt;
	logic tick;
	wire tick_wrap = tick_cnt == TICK_LAST;
	wire [TW-1:0] next_tick_cnt = tick_wrap ? '0 : tick_cnt + TW'(1);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tick_cnt <= '0; // RULE11
			tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt; // RULE11
			tick <= tick_wrap;
		end
	end

	// ****************************************************************
	// Write decode and clamping
	// ****************************************************************
	wire [1:0] wr_chan = addr_in[3:2];
	wire [1:0] fld = addr_in[1:0];
	wire loc_pkg::sel_t wr_sel = wdata_in[4:0];
	// Application-only codes are refused from the register port.
	wire wr_sel_ok = wr_sel < loc_pkg::SEL_APP_FIRST; // RULE8
	wire [15:0] wr_on = (wdata_in > loc_pkg::ON_DELAY_MAX_MS) ?
		loc_pkg::ON_DELAY_MAX_MS : wdata_in; // RULE1
	wire [15:0] wr_hold = (wdata_in > loc_pkg::HOLD_MAX_MS) ?
		loc_pkg::HOLD_MAX_MS : wdata_in; // RULE2

	// ****************************************************************
	// Channels
	// ****************************************************************
	chan_if ch [loc_pkg::NCHAN] ();
	loc_pkg::sel_t sw_sel [loc_pkg::NCHAN];
	loc_pkg::sel_t eff_sel [loc_pkg::NCHAN];
	logic [15:0] on_dly [loc_pkg::NCHAN];
	logic [15:0] hold [loc_pkg::NCHAN];
	logic neg [loc_pkg::NCHAN];
	logic [15:0] chan_rd [loc_pkg::NCHAN];
	logic [loc_pkg::NCHAN-1:0] state_vec;
	logic [loc_pkg::NCHAN-1:0] pin_vec;

	genvar i;
	generate
		for (i = 0; i < loc_pkg::NCHAN; i++) begin : g_chan
			wire wr_here = wr_in && (wr_chan == 2'(i));
			wire [1:0] app_code = app_code_in[2*i +: 2];
			wire loc_pkg::sel_t sel = app_valid_in[i] ?
				{3'b111, app_code} : sw_sel[i]; // RULE8
			wire is_app = sel >= loc_pkg::SEL_APP_FIRST;
			wire sel_cond = is_app ? app_cond_in[sel[1:0]] :
				((sel == loc_pkg::SEL_NONE) ? 1'b0 : cond_in[sel]);
			wire fixed = (sel == loc_pkg::SEL_NO_FAULT) ||
				(sel == loc_pkg::SEL_DC_PRE) ||
				(sel == loc_pkg::SEL_LINE_CTR);

			assign eff_sel[i] = sel;
			assign ch[i].tick = tick;
			assign ch[i].cond = sel_cond;
			assign ch[i].force_pos = fixed; // RULE5
			assign ch[i].zero_hold = fixed; // RULE7
			assign ch[i].zero_on = fixed ||
				(sel == loc_pkg::SEL_OUT_CTR); // RULE6
			assign ch[i].active_low = neg[i];
			assign ch[i].on_delay = on_dly[i];
			assign ch[i].hold_time = hold[i];
			assign state_vec[i] = ch[i].state;
			assign pin_vec[i] = ch[i].pin;
			assign chan_rd[i] =
				(fld == loc_pkg::FLD_ASSIGN) ? {11'h000, eff_sel[i]} :
				(fld == loc_pkg::FLD_ON_DELAY) ? on_dly[i] :
				(fld == loc_pkg::FLD_HOLD) ? hold[i] :
				{15'h0000, neg[i]};

			always_ff @(posedge clk_sys_in) begin
				if (rst_in) begin
					sw_sel[i] <= loc_pkg::SEL_NONE;
					on_dly[i] <= loc_pkg::ON_DELAY_RESET;
					hold[i] <= loc_pkg::HOLD_RESET;
					neg[i] <= loc_pkg::POLARITY_RESET;
				end else if (wr_here) begin
					case (fld)
						loc_pkg::FLD_ASSIGN: begin
							if (wr_sel_ok) begin
								sw_sel[i] <= wr_sel; // RULE8
							end
						end
						loc_pkg::FLD_ON_DELAY: on_dly[i] <= wr_on;
						loc_pkg::FLD_HOLD: hold[i] <= wr_hold;
						default: neg[i] <= wdata_in[0];
					endcase
				end
			end

			chan_timer u_chan (
				.clk_sys_in(clk_sys_in),
				.rst_in(rst_in),
				.c(ch[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Read path
	// ****************************************************************
	wire [15:0] status_word = {9'h000, pin_vec, 1'b0, state_vec};
	wire chan_hit = wr_chan < 2'(loc_pkg::NCHAN);
	wire [15:0] rd_word = chan_hit ? chan_rd[wr_chan] :
		(addr_in == loc_pkg::REG_STATUS) ? status_word : 16'h0000;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
		end else begin
			rdata_out <= rd_in ? rd_word : 16'h0000;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign ext_logic_out_a_out = ch[0].pin;
	assign ext_logic_out_b_out = ch[1].pin;
	assign analog_reuse_logic_out_out = ch[2].pin;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			first_analog_out_out <= ANA_MIN;
		end else begin
			first_analog_out_out <= ch[2].pin ? ANA_MAX : ANA_MIN; // RULE9
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_analog_level: assert property ( // RULE9
		@(posedge clk_sys_in) disable iff (rst_in)
		##1 first_analog_out_out == ($past(analog_reuse_logic_out_out) ?
		ANA_MAX : ANA_MIN))
		else $error("analog level does not match logic state");
	a_app_code_block: assert property ( // RULE8
		@(posedge clk_sys_in) disable iff (rst_in)
		wr_in && addr_in == 4'h0 && !wr_sel_ok |=> $stable(sw_sel[0]))
		else $error("application-only code accepted from register port");
	// The tick register is one cycle behind the wrap, so the prescaler
	// already stands at zero while the tick is high.
	a_tick_spacing: assert property ( // RULE11
		@(posedge clk_sys_in) disable iff (rst_in)
		tick |-> tick_cnt == '0 || TICK_CYCLES == 1)
		else $error("millisecond tick out of phase");
	a_reset_clear: assert property ( // RULE11
		@(posedge clk_sys_in)
		rst_in |=> tick_cnt == '0 && !tick && state_vec == '0)
		else $error("counters not cleared by reset");
	a_on_delay_range: assert property ( // RULE1
		@(posedge clk_sys_in) disable iff (rst_in)
		on_dly[0] <= loc_pkg::ON_DELAY_MAX_MS &&
		hold[0] <= loc_pkg::HOLD_MAX_MS)
		else $error("delay setting out of range");
endmodule : logic_output_conditioner
`default_nettype wire
